// ### src/artc_defines.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * conversion result transfer controller.
 * Assumes byte addressing on a 32-bit Avalon-MM slave port.
 */
`ifndef ARTC_DEFINES_VH
`define ARTC_DEFINES_VH

// register byte offsets
`define ARTC_OFS_CTRL 8'h00
`define ARTC_OFS_START_ADDR 8'h04
`define ARTC_OFS_COUNT 8'h08
`define ARTC_OFS_STATUS 8'h0C
`define ARTC_OFS_MASK 8'h10
`define ARTC_OFS_RESULT 8'h14
`define ARTC_OFS_PROGRESS 8'h18
`define ARTC_OFS_SCAN 8'h1C

// control fields
`define ARTC_CTRL_ENABLE 0
`define ARTC_CTRL_DUAL 1
`define ARTC_CTRL_REPEAT 2
`define ARTC_CTRL_IRQ_EN 3
`define ARTC_CTRL_TIMER_TRIG 4
`define ARTC_CTRL_SOFT_START 5

// status and mask fields
`define ARTC_ST_BLOCK_DONE 0
`define ARTC_ST_OVERRUN 1
`define ARTC_ST_WIDTH 2

// reset values
`define ARTC_RST_CTRL 32'h0000_0000
`define ARTC_RST_START_ADDR 32'h0000_0000
`define ARTC_RST_COUNT 8'h00
`define ARTC_RST_MASK 2'h0
`define ARTC_RST_SCAN_TOP 3'h0

// converter timing
`define ARTC_CONV_TIME_NS 64'd1000
`define ARTC_CLK_PERIOD_NS 64'd5
`define ARTC_RESULT_BITS 10
`define ARTC_RESULT_STEPS 1024

`endif

// ### src/artc_trigger_sync.v
/*
 * Brings the timer compare output into the system clock domain and turns
 * its rising edge into a one-cycle start pulse.
 * Assumes the compare output is asynchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module artc_trigger_sync (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // compare output and start pulse
    input wire timer_compare_channel,
    output reg start_pulse
);
    reg meta;
    reg sync;
    reg sync_q;

    always @(posedge clk_sys) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_q <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            meta <= timer_compare_channel;
            sync <= meta;
            sync_q <= sync;
            // edge of the compare output, no software in the path
            start_pulse <= sync & ~sync_q;
        end
    end
endmodule
`default_nettype wire

// ### src/artc_converter.v
/*
 * Behavioural stand-in for the ten-bit converter: a start begins a fixed
 * conversion time, then the sampled input code is held in the result
 * buffer and a done pulse is given. Scan mode steps channels downward.
 * Assumes analog codes arrive already sampled in clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
`include "artc_defines.vh"
module artc_converter #(
    parameter CONV_CYCLES = 200,
    parameter CHANNELS = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // control
    input wire start,
    input wire [2:0] scan_top,
    // analog codes, one ten-bit field per channel
    input wire [CHANNELS*`ARTC_RESULT_BITS-1:0] sample_codes,
    // result
    output reg [`ARTC_RESULT_BITS-1:0] conversion_result_buffer,
    output reg [2:0] result_channel,
    output reg done,
    output reg busy
);
    reg [15:0] timer;
    reg [2:0] channel;
    reg [2:0] scan_top_q;

    always @(posedge clk_sys) begin
        if (srst) begin
            timer <= 16'h0000;
            channel <= 3'h0;
            conversion_result_buffer <= 10'h000;
            result_channel <= 3'h0;
            done <= 1'b0;
            busy <= 1'b0;
            scan_top_q <= `ARTC_RST_SCAN_TOP;
        end else begin
            done <= 1'b0;
            scan_top_q <= scan_top;
            if (!busy && start) begin
                busy <= 1'b1;
                timer <= CONV_CYCLES[15:0] - 16'h0001;
            end else if (busy) begin
                if (timer == 16'h0000) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    // ten-bit code of vref/1024 steps
                    conversion_result_buffer <=
                        sample_codes[channel*`ARTC_RESULT_BITS +:
                                     `ARTC_RESULT_BITS];
                    result_channel <= channel;
                    // scan steps top, top-1 .. 0, then repeats
                    if (channel == 3'h0)
                        channel <= scan_top;
                    else
                        channel <= channel - 3'h1;
                end else begin
                    timer <= timer - 16'h0001;
                end
            end else if (channel > scan_top || scan_top != scan_top_q) begin
                // a new scan top restarts the sequence at the top
                channel <= scan_top;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/artc_top.v
/*
 * Conversion result transfer controller: moves each finished ten-bit
 * conversion into shared on-chip memory with one stolen bus cycle.
 * Assumes the memory accepts a write in the cycle it is presented and
 * that the cpu holds its bus request while stalled.
 */
// Implementation choices: the address map and register access over Avalon-MM.
// Operation
// - each result moved to memory by hardware
// - first destination from writable start address
// - words per block from count control register
// - single/dual, one-shot/repeat, interrupt on/off modes
// - one bus cycle, cpu stalled exactly one
// - idle cpu sees no stall
// - block-done interrupt only after whole block written; overrun raises irq via mask bit 1
// - repeating single block restarts at start
// - scan sequence results stored in order
// - timer compare starts conversion in hardware
// - result is ten-bit, 1024 steps
`timescale 1ns/100ps
`default_nettype none
`include "artc_defines.vh"
module artc_top #(
    parameter ADDR_WIDTH = 16,
    parameter CHANNELS = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [1:0] avs_response,
    // converter side
    input wire timer_compare_channel,
    input wire [CHANNELS*`ARTC_RESULT_BITS-1:0] sample_codes,
    // shared memory data bus
    input wire cpu_bus_request,
    output reg cpu_stall,
    output reg mem_write,
    output reg [ADDR_WIDTH-1:0] mem_address,
    output reg [15:0] memory_data_bus,
    // interrupt
    output reg irq
);
    localparam CONV_CYCLES_CALC =
        (`ARTC_CONV_TIME_NS + `ARTC_CLK_PERIOD_NS - 64'd1) /
        `ARTC_CLK_PERIOD_NS;
    localparam [15:0] CONV_CYCLES = CONV_CYCLES_CALC[15:0];
    localparam [31:0] RST_START_ADDR = `ARTC_RST_START_ADDR;

    // transfer states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_XFER = 3'b100;

    reg [31:0] ctrl;
    reg [ADDR_WIDTH-1:0] start_addr;
    reg [7:0] transfer_count_control;
    reg [1:0] status;
    reg [1:0] mask;
    reg [2:0] scan_top;
    reg [2:0] state;
    reg [ADDR_WIDTH-1:0] cur_addr;
    reg [7:0] remaining;
    reg active_block;
    reg pending;
    reg one_shot_done;
    reg [9:0] pend_data;
    reg soft_start;
    reg done_event;
    reg overrun_event;
    reg [31:0] next_readdata;
    reg [1:0] next_response;
    wire trig_pulse;
    wire conv_done;
    wire conv_busy;
    wire [9:0] conv_data;
    wire [2:0] conv_chan;
    wire start_conv;
    wire enable;
    wire bus_access;
    wire [1:0] status_set;
    wire [31:0] start_merged;

    // merges byte lanes of a write into a register word
    function [31:0] be_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        integer i;
        begin
            be_merge = old_val;
            for (i = 0; i < 4; i = i + 1)
                if (be[i])
                    be_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
    endfunction

    assign enable = ctrl[`ARTC_CTRL_ENABLE];
    assign bus_access = (avs_read | avs_write) & avs_waitrequest;
    assign start_conv = enable &
        ((ctrl[`ARTC_CTRL_TIMER_TRIG] & trig_pulse) | soft_start);
    assign status_set = {overrun_event, done_event};
    assign start_merged = be_merge({{(32-ADDR_WIDTH){1'b0}}, start_addr},
        avs_writedata, avs_byteenable);

    artc_trigger_sync u_trig (
        .clk_sys(clk_sys),
        .srst(srst),
        .timer_compare_channel(timer_compare_channel),
        .start_pulse(trig_pulse)
    );

    artc_converter #(
        .CONV_CYCLES(CONV_CYCLES),
        .CHANNELS(CHANNELS)
    ) u_conv (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(start_conv),
        .scan_top(scan_top),
        .sample_codes(sample_codes),
        .conversion_result_buffer(conv_data),
        .result_channel(conv_chan),
        .done(conv_done),
        .busy(conv_busy)
    );

    // read data mux
    always @* begin
        next_readdata = 32'h0000_0000;
        next_response = 2'b00;
        case (avs_address)
            `ARTC_OFS_CTRL: next_readdata = ctrl;
            `ARTC_OFS_START_ADDR: next_readdata[ADDR_WIDTH-1:0] = start_addr;
            `ARTC_OFS_COUNT: next_readdata[7:0] = transfer_count_control;
            `ARTC_OFS_STATUS: next_readdata[1:0] = status;
            `ARTC_OFS_MASK: next_readdata[1:0] = mask;
            `ARTC_OFS_RESULT:
                next_readdata = {19'h0, conv_chan, conv_data};
            `ARTC_OFS_PROGRESS:
                next_readdata = {state, conv_busy, active_block, 3'h0,
                                 remaining, {(16-ADDR_WIDTH){1'b0}},
                                 cur_addr};
            `ARTC_OFS_SCAN: next_readdata[2:0] = scan_top;
            default: next_response = 2'b10;
        endcase
    end

    // avalon slave: two wait cycles, answer on the second edge
    always @(posedge clk_sys) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
            ctrl <= `ARTC_RST_CTRL;
            start_addr <= RST_START_ADDR[ADDR_WIDTH-1:0];
            transfer_count_control <= `ARTC_RST_COUNT;
            mask <= `ARTC_RST_MASK;
            scan_top <= `ARTC_RST_SCAN_TOP;
            status <= 2'h0;
            soft_start <= 1'b0;
        end else begin
            soft_start <= 1'b0;
            avs_waitrequest <= 1'b1;
            // events set, reads clear; a set in the same cycle wins
            status <= status | status_set;
            if (bus_access && avs_waitrequest) begin
                if (avs_response == 2'b11) begin
                    avs_waitrequest <= 1'b0;
                end
            end
            if ((avs_read | avs_write) && avs_waitrequest &&
                    avs_response != 2'b11) begin
                avs_response <= 2'b11;
            end else if ((avs_read | avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_response <= next_response;
                avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
                if (avs_read && avs_address == `ARTC_OFS_STATUS)
                    status <= status_set;
                if (avs_write) begin
                    case (avs_address)
                        `ARTC_OFS_CTRL: begin
                            ctrl <= be_merge(ctrl, avs_writedata,
                                             avs_byteenable) &
                                    32'h0000_001F;
                            soft_start <= avs_byteenable[0] &
                                avs_writedata[`ARTC_CTRL_SOFT_START];
                        end
                        `ARTC_OFS_START_ADDR:
                            start_addr <=
                                start_merged[ADDR_WIDTH-1:0];
                        `ARTC_OFS_COUNT:
                            if (avs_byteenable[0])
                                transfer_count_control <=
                                    avs_writedata[7:0];
                        `ARTC_OFS_MASK:
                            if (avs_byteenable[0])
                                mask <= avs_writedata[1:0];
                        `ARTC_OFS_SCAN:
                            if (avs_byteenable[0])
                                scan_top <= avs_writedata[2:0];
                        default: ;
                    endcase
                end
            end else begin
                avs_response <= 2'b00;
            end
        end
    end

    // transfer engine
    always @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_IDLE;
            cur_addr <= {ADDR_WIDTH{1'b0}};
            remaining <= 8'h00;
            active_block <= 1'b0;
            pending <= 1'b0;
            one_shot_done <= 1'b0;
            pend_data <= 10'h000;
            cpu_stall <= 1'b0;
            mem_write <= 1'b0;
            mem_address <= {ADDR_WIDTH{1'b0}};
            memory_data_bus <= 16'h0000;
            done_event <= 1'b0;
            overrun_event <= 1'b0;
            irq <= 1'b0;
        end else begin
            cpu_stall <= 1'b0;
            mem_write <= 1'b0;
            done_event <= 1'b0;
            overrun_event <= 1'b0;
            irq <= |(status & mask);
            if (conv_done && enable) begin
                if (pending)
                    overrun_event <= 1'b1;
                pending <= 1'b1;
                pend_data <= conv_data;
            end
            case (state)
                ST_IDLE: begin
                    if (!enable) begin
                        // disabling re-arms a finished one-shot run
                        one_shot_done <= 1'b0;
                        pending <= 1'b0;
                    end else if (!one_shot_done &&
                            transfer_count_control != 8'h00) begin
                        cur_addr <= start_addr;
                        remaining <= transfer_count_control;
                        active_block <= 1'b0;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!enable) begin
                        state <= ST_IDLE;
                    end else if (pending) begin
                        // one stolen bus cycle per word
                        state <= ST_XFER;
                        cpu_stall <= cpu_bus_request;
                    end
                end
                ST_XFER: begin
                    mem_write <= 1'b1;
                    mem_address <= cur_addr;
                    memory_data_bus <= {6'h00, pend_data};
                    if (!(conv_done && enable))
                        pending <= 1'b0;
                    state <= ST_WAIT;
                    if (remaining == 8'h01) begin
                        // block written; flag only now
                        done_event <= ctrl[`ARTC_CTRL_IRQ_EN];
                        remaining <= transfer_count_control;
                        if (ctrl[`ARTC_CTRL_DUAL] && !active_block) begin
                            active_block <= 1'b1;
                            cur_addr <= cur_addr + 1'b1;
                        end else if (ctrl[`ARTC_CTRL_REPEAT]) begin
                            cur_addr <= start_addr;
                            active_block <= 1'b0;
                        end else begin
                            state <= ST_IDLE; // one-shot end
                            one_shot_done <= 1'b1;
                        end
                    end else begin
                        cur_addr <= cur_addr + 1'b1;
                        remaining <= remaining - 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verification/artc_top_assertions.sv
/*
 * Concurrent checks on the ports of the transfer controller top.
 * Assumes one clock domain, synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module artc_top_assertions #(
    parameter ADDR_WIDTH = 16,
    parameter CHANNELS = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // memory side
    input wire logic cpu_bus_request,
    input wire logic cpu_stall,
    input wire logic mem_write,
    input wire logic [15:0] memory_data_bus,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_req_rise;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_answer;
        avs_waitrequest ##[1:2] !avs_waitrequest;
    endsequence
    sequence s_stall_write;
        cpu_stall ##1 mem_write;
    endsequence

    a_wait_fixed: assert property (s_req_rise |-> s_answer)
        else $error("register answer not on time");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_err: assert property (!avs_waitrequest && avs_address > 8'h1F
        && (avs_read || avs_write) |-> avs_response == 2'b10)
        else $error("unmapped access not answered with error");
    a_stall_then_write: assert property (cpu_stall |-> s_stall_write)
        else $error("stall without a memory write after it");
    a_stall_single: assert property (cpu_stall |=> !cpu_stall)
        else $error("cpu stalled for more than one cycle");
    a_write_single: assert property (mem_write |=> !mem_write)
        else $error("memory write longer than one cycle");
    a_busy_stalls: assert property (mem_write && $past(cpu_bus_request)
        && $past(cpu_bus_request, 2) |-> $past(cpu_stall))
        else $error("busy cpu not stalled before transfer");
    a_idle_no_stall: assert property (!cpu_bus_request
        && !$past(cpu_bus_request) |-> !cpu_stall)
        else $error("idle cpu was stalled");
    a_irq_after_write: assert property ($rose(irq) |-> $past(mem_write)
        || $past(mem_write, 2) || $past(mem_write, 3))
        else $error("interrupt not right after a block write");
    a_result_ten_bit: assert property (mem_write
        |-> memory_data_bus[15:10] == 6'h00)
        else $error("result wider than ten bits");
endmodule
bind artc_top artc_top_assertions #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .CHANNELS(CHANNELS)
) i_artc_top_assertions (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .cpu_bus_request(cpu_bus_request), .cpu_stall(cpu_stall),
    .mem_write(mem_write), .memory_data_bus(memory_data_bus), .irq(irq)
);
`default_nettype wire

// ### verification/artc_mem_model.sv
/*
 * On-chip memory shared with the cpu, seen from the transfer side.
 * Assumes word addresses; keeps 256 words, indexed by the low eight address bits.
 */
`timescale 1ns/100ps
`default_nettype none
module artc_mem_model (
    // clock
    input wire logic clk_sys,
    // write port
    input wire logic mem_write,
    input wire logic [15:0] mem_address,
    input wire logic [15:0] memory_data_bus
);
    logic [15:0] mem [0:255];
    // a write is taken in the cycle it is presented
    always @(posedge clk_sys) begin
        if (mem_write === 1'b1) begin
            mem[mem_address[7:0]] <= memory_data_bus;
        end
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
/*
 * Self-checking bench of the transfer controller top.
 * Assumes the register map and timing of the designer's defines header.
 */
`timescale 1ns/100ps
`default_nettype none
`include "artc_defines.vh"
module tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic timer_compare_channel = 1'b0;
    logic [79:0] sample_codes;
    logic cpu_bus_request = 1'b0;
    logic cpu_stall, mem_write, irq;
    logic [15:0] mem_address, memory_data_bus;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic seen_stall;
    int failures = 0;
    int samples_checked = 0;
    int last_k;

    always #2.5 clk_sys = ~clk_sys;

    artc_top i_artc_top (.clk_sys(clk_sys), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .timer_compare_channel(timer_compare_channel),
        .sample_codes(sample_codes), .cpu_bus_request(cpu_bus_request),
        .cpu_stall(cpu_stall), .mem_write(mem_write),
        .mem_address(mem_address), .memory_data_bus(memory_data_bus),
        .irq(irq));
    artc_mem_model i_artc_mem_model (.clk_sys(clk_sys),
        .mem_write(mem_write), .mem_address(mem_address),
        .memory_data_bus(memory_data_bus));

    function automatic logic [9:0] code(input int n);
        return 10'h3F0 + n[9:0];
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        k = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge clk_sys);
            k++;
        end
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 50) begin
            failures++;
            end_of_test();
        end
        @(posedge clk_sys);
    endtask

    // timer edge starts a conversion; then wait for the transfer
    task automatic convert(input logic exp_wr, input logic [15:0] ea,
                           input logic [9:0] ed, input logic exp_stall);
        int k;
        seen_stall = 1'b0;
        timer_compare_channel <= 1'b1;
        repeat (4) @(posedge clk_sys);
        timer_compare_channel <= 1'b0;
        for (k = 0; k < 400; k++) begin
            @(posedge clk_sys);
            if (cpu_stall === 1'b1) seen_stall = 1'b1;
            if (mem_write === 1'b1) break;
        end
        last_k = k;
        if (!exp_wr) begin
            check(k, 400);
        end else if (k == 400) begin
            failures++;
            end_of_test();
        end else begin
            check({16'h0, mem_address}, {16'h0, ea});
            check({22'h0, memory_data_bus[9:0]}, {22'h0, ed});
            check({31'h0, seen_stall}, {31'h0, exp_stall});
        end
    endtask

    task automatic test_regs();
        for (int a = 0; a <= 16; a += 4) begin
            bus(1'b0, a[7:0], 32'h0);
            check(rd, 32'h0);
            check({30'h0, rsp}, 32'h0);
        end
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        check({30'h0, rsp}, 32'h2);
        $display("test_regs done");
    endtask

    task automatic test_block();
        int k1;
        bus(1'b1, `ARTC_OFS_SCAN, 32'h2);
        bus(1'b1, `ARTC_OFS_START_ADDR, 32'h0200);
        bus(1'b1, `ARTC_OFS_COUNT, 32'h3);
        bus(1'b1, `ARTC_OFS_MASK, 32'h1);
        bus(1'b1, `ARTC_OFS_CTRL, 32'h1D);
        bus(1'b0, `ARTC_OFS_START_ADDR, 32'h0);
        check(rd, 32'h0200);
        cpu_bus_request <= 1'b1;
        convert(1'b1, 16'h0200, code(2), 1'b1);
        k1 = last_k;
        convert(1'b1, 16'h0201, code(1), 1'b1);
        repeat (5) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        convert(1'b1, 16'h0202, code(0), 1'b1);
        repeat (5) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, `ARTC_OFS_STATUS, 32'h0);
        check(rd, 32'h1);
        repeat (3) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        cpu_bus_request <= 1'b0;
        convert(1'b1, 16'h0200, code(2), 1'b0);
        check(last_k, k1);
        check({16'h0, i_artc_mem_model.mem[8'h01]}, {22'h0, code(1)});
        bus(1'b1, `ARTC_OFS_CTRL, 32'h0);
        $display("test_block done");
    endtask

    task automatic test_dual();
        bus(1'b1, `ARTC_OFS_SCAN, 32'h0);
        bus(1'b1, `ARTC_OFS_START_ADDR, 32'h0300);
        bus(1'b1, `ARTC_OFS_COUNT, 32'h2);
        bus(1'b1, `ARTC_OFS_MASK, 32'h0);
        bus(1'b1, `ARTC_OFS_STATUS, 32'h0);
        bus(1'b0, `ARTC_OFS_STATUS, 32'h0);
        bus(1'b1, `ARTC_OFS_CTRL, 32'h1B);
        convert(1'b1, 16'h0300, code(0), 1'b0);
        convert(1'b1, 16'h0301, code(0), 1'b0);
        repeat (5) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, `ARTC_OFS_STATUS, 32'h0);
        check(rd, 32'h1);
        convert(1'b1, 16'h0302, code(0), 1'b0);
        convert(1'b1, 16'h0303, code(0), 1'b0);
        bus(1'b0, `ARTC_OFS_STATUS, 32'h0);
        check(rd, 32'h1);
        convert(1'b0, 16'h0, 10'h0, 1'b0);
        bus(1'b1, `ARTC_OFS_CTRL, 32'h0);
        bus(1'b1, `ARTC_OFS_COUNT, 32'h1);
        bus(1'b1, `ARTC_OFS_CTRL, 32'h21);
        convert(1'b1, 16'h0300, code(0), 1'b0);
        bus(1'b0, `ARTC_OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        $display("test_dual done");
    endtask

    initial begin
        for (int n = 0; n < 8; n++) sample_codes[n*10+:10] = code(n);
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        test_regs();
        test_block();
        test_dual();
        end_of_test();
    end
endmodule
`default_nettype wire
